// ===== verilog/sbtc_pkg.sv
/*
 * Shared constants for the 16-bit timer/counter: register byte offsets,
 * control field positions, reset values and bus response codes.
 * Assumes a 32-bit AXI4-Lite bus with byte addresses.
 */
package sbtc_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'h00;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
   localparam logic [7:0] ADDR_FLAG = 8'h08;
   localparam logic [7:0] ADDR_ENABLE = 8'h0c;
   localparam logic [7:0] ADDR_CONTROL = 8'h10;
   localparam int RUN_BIT = 0;
   localparam int CLK_SRC_BIT = 1;
   localparam int SYNC_DIS_BIT = 2;
   localparam int OSC_EN_BIT = 3;
   localparam int PRESCALE_LSB = 4;
   localparam logic [7:0] CONTROL_MASK = 8'h3f;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam int OVF_BIT = 0;
   localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
   localparam int PIN_EXT_CLOCK = 0;
   localparam int PIN_OSC_IN = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      WR_COLLECT = 2'h1,
      WR_RESP = 2'h2
   } sbtc_wr_state_t;
endpackage : sbtc_pkg

// ===== verilog/sbtc_tick_gen.sv
/*
 * Count-enable generator: instruction-cycle divider, external clock edge
 * detection with optional two-flop synchroniser, and the prescaler.
 * Assumes the external clock input is already sampled by clk.
 */
`timescale 1ns/1ps
module sbtc_tick_gen (
   input wire logic clk,
   input wire logic reset,
   input wire logic run,
   input wire logic clockSource,
   input wire logic syncDisable,
   input wire logic [1:0] prescale,
   input wire logic extClock,
   output logic countTick
);
   logic [1:0] instrCnt_q;
   logic sync1_q;
   logic sync2_q;
   logic syncPrev_q;
   logic rawPrev_q;
   logic [2:0] preCnt_q;
   logic instrTick;
   logic extEdge;
   logic srcTick;
   logic [2:0] preMask;

   // One instruction cycle lasts four clocks.
   always_ff @(posedge clk) begin
      if (reset) instrCnt_q <= 2'h0;
      else instrCnt_q <= instrCnt_q + 2'h1;
   end
   assign instrTick = (instrCnt_q == sbtc_pkg::INSTR_DIV_LAST);

   always_ff @(posedge clk) begin
      if (reset) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         syncPrev_q <= 1'b0;
         rawPrev_q <= 1'b0;
      end else begin
         sync1_q <= extClock;
         sync2_q <= sync1_q;
         syncPrev_q <= sync2_q;
         rawPrev_q <= extClock;
      end
   end

   // Rising edges only; the unsynchronised path saves two clocks of latency.
   assign extEdge = syncDisable ? (extClock & ~rawPrev_q) : (sync2_q & ~syncPrev_q); // R6 R10
   assign srcTick = clockSource ? extEdge : instrTick; // R4 R5
   assign preMask = 3'((4'h1 << prescale) - 4'h1); // R9

   always_ff @(posedge clk) begin
      if (reset || !run) preCnt_q <= 3'h0;
      else if (srcTick) preCnt_q <= preCnt_q + 3'h1;
   end
   assign countTick = run & srcTick & ((preCnt_q & preMask) == preMask); // R7 R9
endmodule : sbtc_tick_gen

// ===== verilog/sbtc_timer.sv
/*
 * 16-bit timer/counter with AXI4-Lite register slave, overflow interrupt,
 * capture/compare reset input and crystal oscillator pin control.
 * Assumes a single 200 MHz clock and synchronous active-high reset.
 */
// Our own choice: register access over AXI4-Lite.
// Overview of operation
// (R1) 16-bit readable writable count, wraps to zero
// (R2) Wrap past maximum latches overflow flag
// (R3) Interrupt only while overflow enable set
// (R4) Control bit 1 selects external or instruction clock
// (R5) Timer mode counts prescaled instruction cycles
// (R6) Counter mode counts rising external edges only
// (R7) Counts only while run bit set
// (R8) Capture/compare reset input clears count
// (R9) Prescale field selects divide 1, 2, 4, 8
// (R10) Control bit 2 disables external clock sync
// (R11) Oscillator enable forces both pins to inputs
// (R12) Bits 7:6 read zero; control resets zero
`timescale 1ns/1ps
module sbtc_timer (
   input wire logic clk,
   input wire logic reset,
   input wire logic [sbtc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sbtc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic captureReset,
   input wire logic [1:0] portDirection,
   input wire logic [1:0] portOut,
   input wire logic [1:0] pinIn,
   output logic [1:0] pinOut,
   output logic [1:0] pinOe,
   output logic irq
);
   sbtc_pkg::sbtc_wr_state_t wrState_q;
   logic awHeld_q;
   logic wHeld_q;
   logic [sbtc_pkg::ADDR_W-1:0] wrAddr_q;
   logic [31:0] wrData_q;
   logic [3:0] wrStrb_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [sbtc_pkg::ADDR_W-1:0] rdAddr_q;
   logic [7:0] control_q;
   logic [15:0] count_q;
   logic flag_q;
   logic enable_q;
   logic [1:0] pinOut_q;
   logic [1:0] pinOe_q;
   logic countTick;
   logic doWrite;
   logic byteWr;
   logic wrLow;
   logic wrHigh;
   logic wrFlag;
   logic wrEnable;
   logic wrControl;
   logic ovfEvent;

   // Word-aligned decode shared by the read and write paths.
   function automatic logic regHit(input logic [7:0] addr, input logic [7:0] target);
      regHit = (addr[7:2] == target[7:2]);
   endfunction : regHit

   function automatic logic mapped(input logic [7:0] addr);
      mapped = regHit(addr, sbtc_pkg::ADDR_COUNT_LOW) | regHit(addr, sbtc_pkg::ADDR_COUNT_HIGH)
         | regHit(addr, sbtc_pkg::ADDR_FLAG) | regHit(addr, sbtc_pkg::ADDR_ENABLE)
         | regHit(addr, sbtc_pkg::ADDR_CONTROL);
   endfunction : mapped

   // Write address and data are taken independently, in either order.
   assign s_axi_awready = (wrState_q == sbtc_pkg::WR_COLLECT) && !awHeld_q;
   assign s_axi_wready = (wrState_q == sbtc_pkg::WR_COLLECT) && !wHeld_q;
   assign s_axi_bvalid = (wrState_q == sbtc_pkg::WR_RESP);
   assign s_axi_bresp = bresp_q;
   assign doWrite = (wrState_q == sbtc_pkg::WR_COLLECT) && awHeld_q && wHeld_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         wrState_q <= sbtc_pkg::WR_COLLECT;
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         wrAddr_q <= '0;
         wrData_q <= 32'h0;
         wrStrb_q <= 4'h0;
         bresp_q <= sbtc_pkg::RESP_OKAY;
      end else begin
         case (wrState_q)
            sbtc_pkg::WR_COLLECT: begin
               if (s_axi_awvalid && s_axi_awready) begin
                  awHeld_q <= 1'b1;
                  wrAddr_q <= s_axi_awaddr;
               end
               if (s_axi_wvalid && s_axi_wready) begin
                  wHeld_q <= 1'b1;
                  wrData_q <= s_axi_wdata;
                  wrStrb_q <= s_axi_wstrb;
               end
               if (doWrite) begin
                  wrState_q <= sbtc_pkg::WR_RESP;
                  bresp_q <= mapped(wrAddr_q) ? sbtc_pkg::RESP_OKAY : sbtc_pkg::RESP_SLVERR;
               end
            end
            sbtc_pkg::WR_RESP: begin
               if (s_axi_bready) begin
                  wrState_q <= sbtc_pkg::WR_COLLECT;
                  awHeld_q <= 1'b0;
                  wHeld_q <= 1'b0;
               end
            end
            default: begin
               wrState_q <= sbtc_pkg::WR_COLLECT;
               awHeld_q <= 1'b0;
               wHeld_q <= 1'b0;
            end
         endcase
      end
   end

   // Every register is at most eight bits wide, in the low byte lane.
   assign byteWr = doWrite && wrStrb_q[0];
   assign wrLow = byteWr && regHit(wrAddr_q, sbtc_pkg::ADDR_COUNT_LOW);
   assign wrHigh = byteWr && regHit(wrAddr_q, sbtc_pkg::ADDR_COUNT_HIGH);
   assign wrFlag = byteWr && regHit(wrAddr_q, sbtc_pkg::ADDR_FLAG);
   assign wrEnable = byteWr && regHit(wrAddr_q, sbtc_pkg::ADDR_ENABLE);
   assign wrControl = byteWr && regHit(wrAddr_q, sbtc_pkg::ADDR_CONTROL);

   chk_bvalid_hold: assert property (@(posedge clk) disable iff (reset)
      (s_axi_bvalid && !s_axi_bready)
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");

   chk_wr_slverr: assert property (@(posedge clk) disable iff (reset)
      (doWrite && !mapped(wrAddr_q))
      |=> s_axi_bvalid && s_axi_bresp == sbtc_pkg::RESP_SLVERR)
      else $error("unmapped write not answered with slave error");

   chk_ctrl_write: assert property (@(posedge clk) disable iff (reset) // R12
      wrControl
      |=> control_q[7:6] == 2'h0 && control_q[5:0] == $past(wrData_q[5:0]))
      else $error("control write stored wrong value");

   always_ff @(posedge clk) begin
      if (reset) control_q <= sbtc_pkg::CONTROL_RESET; // R12
      else if (wrControl) control_q <= wrData_q[7:0] & sbtc_pkg::CONTROL_MASK; // R12
   end

   always_ff @(posedge clk) begin
      if (reset) enable_q <= 1'b0;
      else if (wrEnable) enable_q <= wrData_q[sbtc_pkg::OVF_BIT];
   end

   sbtc_tick_gen u_tick (
      .clk(clk),
      .reset(reset),
      .run(control_q[sbtc_pkg::RUN_BIT]),
      .clockSource(control_q[sbtc_pkg::CLK_SRC_BIT]),
      .syncDisable(control_q[sbtc_pkg::SYNC_DIS_BIT]),
      .prescale(control_q[sbtc_pkg::PRESCALE_LSB +: 2]),
      .extClock(pinIn[sbtc_pkg::PIN_EXT_CLOCK]),
      .countTick(countTick)
   );

   // The capture reset beats a software write, which beats a count step.
   always_ff @(posedge clk) begin
      if (reset || captureReset) begin // R8
         count_q <= sbtc_pkg::COUNT_RESET;
      end else if (wrLow || wrHigh) begin
         if (wrLow) count_q[7:0] <= wrData_q[7:0]; // R1
         if (wrHigh) count_q[15:8] <= wrData_q[7:0]; // R1
      end else if (countTick) begin
         count_q <= count_q + 16'h1; // R1 R7
      end
   end

   assign ovfEvent = countTick && !captureReset && !wrLow && !wrHigh
      && (count_q == sbtc_pkg::COUNT_MAX);

   chk_low_write: assert property (@(posedge clk) disable iff (reset) // R1
      (wrLow && !captureReset)
      |=> count_q[7:0] == $past(wrData_q[7:0]))
      else $error("count low byte write lost");

   chk_high_write: assert property (@(posedge clk) disable iff (reset) // R1
      (wrHigh && !captureReset)
      |=> count_q[15:8] == $past(wrData_q[7:0]))
      else $error("count high byte write lost");

   chk_stopped_idle: assert property (@(posedge clk) disable iff (reset) // R7
      !control_q[sbtc_pkg::RUN_BIT]
      |-> !countTick)
      else $error("count tick while stopped");

   // A wrap in the same cycle as a write-one-to-clear keeps the flag set.
   always_ff @(posedge clk) begin
      if (reset) flag_q <= 1'b0;
      else flag_q <= ovfEvent | (flag_q & ~(wrFlag & wrData_q[sbtc_pkg::OVF_BIT])); // R2
   end

   assign irq = flag_q & enable_q; // R3

   chk_flag_clear: assert property (@(posedge clk) disable iff (reset) // R2
      (wrFlag && wrData_q[sbtc_pkg::OVF_BIT] && !ovfEvent)
      |=> !flag_q)
      else $error("overflow flag not cleared by write of one");

   chk_flag_sticky: assert property (@(posedge clk) disable iff (reset) // R2
      (flag_q && !(wrFlag && wrData_q[sbtc_pkg::OVF_BIT]))
      |=> flag_q)
      else $error("overflow flag lost without a clear");

   chk_flag_cause: assert property (@(posedge clk) disable iff (reset) // R2
      (!flag_q && !ovfEvent)
      |=> !flag_q)
      else $error("overflow flag set without a wrap");

   // With the oscillator on, the port direction bits are ignored.
   always_ff @(posedge clk) begin
      if (reset) begin
         pinOut_q <= 2'h0;
         pinOe_q <= 2'h0;
      end else begin
         pinOut_q <= portOut;
         pinOe_q <= control_q[sbtc_pkg::OSC_EN_BIT] ? 2'h0 : ~portDirection; // R11
      end
   end
   assign pinOut = pinOut_q;
   assign pinOe = pinOe_q;

   chk_dir_follow: assert property (@(posedge clk) disable iff (reset) // R11
      !control_q[sbtc_pkg::OSC_EN_BIT]
      |=> pinOe == ~$past(portDirection))
      else $error("pin drive did not follow port direction");

   // Read path: one outstanding read; the count is sampled at the address edge.
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= sbtc_pkg::RESP_OKAY;
         rdAddr_q <= '0;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdAddr_q <= s_axi_araddr;
         rresp_q <= mapped(s_axi_araddr) ? sbtc_pkg::RESP_OKAY : sbtc_pkg::RESP_SLVERR;
         if (regHit(s_axi_araddr, sbtc_pkg::ADDR_COUNT_LOW)) rdata_q <= {24'h0, count_q[7:0]};
         else if (regHit(s_axi_araddr, sbtc_pkg::ADDR_COUNT_HIGH)) begin
            rdata_q <= {24'h0, count_q[15:8]};
         end else if (regHit(s_axi_araddr, sbtc_pkg::ADDR_FLAG)) rdata_q <= {31'h0, flag_q};
         else if (regHit(s_axi_araddr, sbtc_pkg::ADDR_ENABLE)) rdata_q <= {31'h0, enable_q};
         else if (regHit(s_axi_araddr, sbtc_pkg::ADDR_CONTROL)) begin
            rdata_q <= {24'h0, control_q & sbtc_pkg::CONTROL_MASK}; // R12
         end else rdata_q <= 32'h0;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   chk_count_step: assert property (@(posedge clk) disable iff (reset) // R1
      (countTick && !captureReset && !wrLow && !wrHigh) |=> count_q == $past(count_q) + 16'h1)
      else $error("count did not step by one");

   chk_wrap_flag: assert property (@(posedge clk) disable iff (reset) // R2
      (countTick && count_q == 16'hffff && !captureReset && !wrLow && !wrHigh)
      |=> (count_q == 16'h0000) && flag_q)
      else $error("wrap did not clear count and set flag");

   chk_irq_gate: assert property (@(posedge clk) disable iff (reset) // R3
      (ovfEvent && enable_q && !wrEnable) |=> irq ##0 (!enable_q || flag_q))
      else $error("enabled overflow gave no interrupt");

   chk_irq_masked: assert property (@(posedge clk) disable iff (reset) // R3
      !enable_q |-> !irq)
      else $error("interrupt raised while disabled");

   chk_timer_mode: assert property (@(posedge clk) disable iff (reset) // R5
      (countTick && !control_q[sbtc_pkg::CLK_SRC_BIT] && !wrControl) |=> !countTick [*3])
      else $error("timer stepped faster than instruction rate");

   chk_rise_only: assert property (@(posedge clk) disable iff (reset) // R6
      (countTick && control_q[sbtc_pkg::CLK_SRC_BIT] && control_q[sbtc_pkg::SYNC_DIS_BIT])
      |-> pinIn[sbtc_pkg::PIN_EXT_CLOCK] && !$past(pinIn[sbtc_pkg::PIN_EXT_CLOCK]))
      else $error("counter stepped without a rising edge");

   chk_sync_delay: assert property (@(posedge clk) disable iff (reset) // R10
      (countTick && control_q[sbtc_pkg::CLK_SRC_BIT] && !control_q[sbtc_pkg::SYNC_DIS_BIT]
      && $stable(control_q)) |-> $past(pinIn[sbtc_pkg::PIN_EXT_CLOCK], 2))
      else $error("synchronised edge not two clocks late");

   chk_count_hold: assert property (@(posedge clk) disable iff (reset) // R7
      (!control_q[sbtc_pkg::RUN_BIT] && !captureReset && !wrLow && !wrHigh)
      |=> count_q == $past(count_q))
      else $error("count moved while stopped");

   chk_cap_reset: assert property (@(posedge clk) disable iff (reset) // R8
      captureReset |=> count_q == 16'h0000)
      else $error("capture reset did not clear count");

   chk_div_eight: assert property (@(posedge clk) disable iff (reset) // R9
      (countTick && control_q[5:4] == 2'h3 && !control_q[sbtc_pkg::CLK_SRC_BIT]
      && !wrControl) |=> !countTick [*8])
      else $error("divide by eight stepped too soon");

   chk_osc_inputs: assert property (@(posedge clk) disable iff (reset) // R11
      control_q[sbtc_pkg::OSC_EN_BIT] |=> pinOe == 2'h0)
      else $error("oscillator pin driven while oscillator on");

   chk_ctrl_reserved: assert property (@(posedge clk) disable iff (reset) // R12
      (rvalid_q && regHit(rdAddr_q, sbtc_pkg::ADDR_CONTROL)) |-> s_axi_rdata[31:6] == 26'h0)
      else $error("reserved control bits read nonzero");

   chk_rvalid_hold: assert property (@(posedge clk) disable iff (reset)
      (s_axi_rvalid && !s_axi_rready)
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data changed before rready");

   chk_rd_slverr: assert property (@(posedge clk) disable iff (reset)
      (s_axi_arvalid && s_axi_arready && !mapped(s_axi_araddr))
      |=> s_axi_rvalid && s_axi_rresp == sbtc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not answered with slave error");

   chk_sync_rise: assert property (@(posedge clk) disable iff (reset) // R6 R10
      (countTick && control_q[sbtc_pkg::CLK_SRC_BIT] && !control_q[sbtc_pkg::SYNC_DIS_BIT]
      && $stable(control_q)) |-> !$past(pinIn[sbtc_pkg::PIN_EXT_CLOCK], 3))
      else $error("synchronised step without a rising edge");
endmodule : sbtc_timer

// ===== tb/sbtc_ext_src.sv
/* External clock source for the timer clock pin pair.
   Assumes the bench calls burst from its own thread, just after a clock edge. */
`timescale 1ns/1ps
module sbtc_ext_src (
   input wire logic clk,
   output logic [1:0] pinLevel
);
   logic level = 1'b0;
   // The crystal side shows the inverse, so the idle pin never mirrors a stale level.
   assign pinLevel = {~level, level};
   // Rests low between bursts, so a stopped source adds no rising edge.
   task automatic burst(input int n, input int h);
      for (int i = 0; i < n; i++) begin
         repeat (6) @(posedge clk);
         level <= 1'b1;
         repeat (h) @(posedge clk);
         level <= 1'b0;
      end
   endtask : burst
endmodule : sbtc_ext_src

// ===== tb/testbench.sv
/* Self-checking bench for the 16-bit timer: registers, both count sources,
   prescale, overflow interrupt, capture reset and pin control.
   Assumes sbtc_pkg, the design and the clock source model are compiled first. */
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic captureReset = 1'b0;
   logic [1:0] portDirection = 2'h3, portOut = 2'h0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, pinOut, pinOe, pinLevel, pinIn;
   logic [31:0] rdata, got;
   int err_total = 0, n_tests = 0, cyc = 0;
   always #2.5 clk = ~clk;
   assign pinIn = (pinOe & pinOut) | (~pinOe & pinLevel);
   sbtc_ext_src src (.clk(clk), .pinLevel(pinLevel));
   sbtc_timer dut (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .captureReset(captureReset), .portDirection(portDirection), .portOut(portOut),
      .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      got = rdata;
   endtask : axr
   task automatic wctl(input logic [31:0] d);
      axw(sbtc_pkg::ADDR_CONTROL, d);
   endtask : wctl
   task automatic wcnt(input logic [15:0] v);
      axw(sbtc_pkg::ADDR_COUNT_LOW, {24'h0, v[7:0]});
      axw(sbtc_pkg::ADDR_COUNT_HIGH, {24'h0, v[15:8]});
   endtask : wcnt
   // Halves are read separately, so callers stop the count first to avoid tearing.
   task automatic rdcnt();
      logic [7:0] lo;
      axr(sbtc_pkg::ADDR_COUNT_LOW);
      lo = got[7:0];
      axr(sbtc_pkg::ADDR_COUNT_HIGH);
      got = {16'h0, got[7:0], lo};
   endtask : rdcnt
   task automatic t_regs();
      axr(sbtc_pkg::ADDR_CONTROL);
      chk("control reset", 32'h0, got);
      wctl(32'hff);
      chk("mapped bresp", 32'h0, {30'h0, bresp});
      axr(sbtc_pkg::ADDR_CONTROL);
      chk("control mask", 32'h3f, got);
      chk("mapped rresp", 32'h0, {30'h0, rresp});
      axw(8'h14, 32'h1);
      chk("unmapped bresp", 32'h2, {30'h0, bresp});
      axr(8'h14);
      chk("unmapped rresp", 32'h2, {30'h0, rresp});
      wctl(32'h0);
      wcnt(16'h1234);
      rdcnt();
      chk("count rw", 32'h1234, got);
   endtask : t_regs
   task automatic t_timer();
      int t0, t1, e;
      for (int ps = 0; ps < 4; ps++) begin
         wcnt(16'h0);
         t0 = cyc;
         wctl({26'h0, ps[1:0], 4'h1});
         repeat (400) @(posedge clk);
         t1 = cyc;
         wctl(32'h0);
         rdcnt();
         // The instruction divider phase is free, so one step either way is allowed.
         e = (t1 - t0) / (4 << ps);
         n_tests++;
         if (got !== 32'(e) && got !== 32'(e - 1) && got !== 32'(e + 1)) begin
            err_total++;
            $display("FAIL timer count expected %0d seen %0d", e, got);
         end
      end
   endtask : t_timer
   task automatic t_counter();
      for (int i = 0; i < 4; i++) begin
         wcnt(16'h0);
         wctl({26'h0, 1'b0, i[1], 1'b0, i[0], 2'h3});
         src.burst(8, 2 + 5 * i[0]);
         repeat (6) @(posedge clk);
         wctl({26'h0, 1'b0, i[1], 1'b0, i[0], 2'h2});
         src.burst(3, 2);
         rdcnt();
         chk("edge count", 32'h8 >> i[1], got);
      end
   endtask : t_counter
   task automatic t_ovf();
      axw(sbtc_pkg::ADDR_ENABLE, 32'h0);
      wcnt(16'hffff);
      wctl(32'h3);
      src.burst(1, 3);
      repeat (6) @(posedge clk);
      wctl(32'h0);
      rdcnt();
      chk("wrap", 32'h0, got);
      axr(sbtc_pkg::ADDR_FLAG);
      chk("flag set", 32'h1, got);
      chk("irq masked", 32'h0, 32'(irq));
      axw(sbtc_pkg::ADDR_ENABLE, 32'h1);
      chk("irq on", 32'h1, 32'(irq));
      axw(sbtc_pkg::ADDR_FLAG, 32'h1);
      chk("irq cleared", 32'h0, 32'(irq));
      axr(sbtc_pkg::ADDR_FLAG);
      chk("flag clear", 32'h0, got);
   endtask : t_ovf
   task automatic t_capture();
      wcnt(16'h5a5a);
      @(posedge clk);
      captureReset <= 1'b1;
      @(posedge clk);
      captureReset <= 1'b0;
      rdcnt();
      chk("capture reset", 32'h0, got);
   endtask : t_capture
   task automatic t_pins();
      @(posedge clk);
      portDirection <= 2'h0;
      portOut <= 2'h2;
      repeat (3) @(posedge clk);
      chk("pin drive", 32'h3, 32'(pinOe));
      chk("pin data", 32'h2, 32'(pinOut));
      wctl(32'h8);
      repeat (3) @(posedge clk);
      chk("osc pins input", 32'h0, 32'(pinOe));
      wctl(32'h0);
   endtask : t_pins
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_timer();
      t_counter();
      t_ovf();
      t_capture();
      t_pins();
      tally_and_finish();
   end
endmodule : testbench
